// file: startup_config_sequencer.v
// Start-up configuration sequencer: memory check, strap sampling, enable delay and ramp hand-off.
`timescale 1ns/1ps
`default_nettype none
`include "startup_consts.vh"
module startup_config_sequencer #(
  parameter NVM_CHECK_CYCLES = `NVM_CHECK_MS * (`CLK_HZ / `MS_PER_S),
  parameter CYCLES_PER_MS = `CLK_HZ / `MS_PER_S
)
(
  // Clock, reset and enable.
  input wire clock,
  input wire rst,
  input wire clk_en,
  // Non-volatile memory image presented to the loader.
  input wire nvm_valid,
  input wire [11:0] nvm_output_voltage_target,
  input wire [7:0] nvm_delay_ms,
  input wire [7:0] nvm_ramp_ms,
  input wire [2:0] nvm_mode,
  // Multi-mode strap pins, already classified by the analog front end.
  input wire [2:0] fine_select_pin,
  input wire [4:0] fine_res_index,
  input wire [2:0] coarse_select_pin,
  input wire [4:0] coarse_res_index,
  input wire [2:0] ss_pin,
  input wire [7:0] ss_delay_ms,
  input wire [7:0] ss_ramp_ms,
  // Enable input.
  input wire enable_in,
  // Register port.
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // Status and hand-off.
  output reg ready,
  output reg ramp_start,
  output reg [7:0] ramp_time_ms,
  output reg [11:0] output_voltage_target
);
  // ==========================================================================
  // State encoding and helpers.
  localparam [4:0] S_NVM = 5'h01;
  localparam [4:0] S_PINS = 5'h02;
  localparam [4:0] S_READY = 5'h04;
  localparam [4:0] S_DELAY = 5'h08;
  localparam [4:0] S_RAMP = 5'h10;
  // Counts cut on purpose to the widths of the counters that meet them.
  localparam [23:0] NVM_CYC = NVM_CHECK_CYCLES[23:0];
  localparam [15:0] MS_CYC = CYCLES_PER_MS[15:0];

  // Nine-entry strap table in 10 mV units, rows coarse, columns fine.
  function [11:0] strap_output_voltage_target;
    input [2:0] c;
    input [2:0] f;
    reg [3:0] k;
    begin
      k = c[1:0] * 4'h3 + {2'h0, f[1:0]};
      case (k)
        4'h0: strap_output_voltage_target = 12'h03C;
        4'h1: strap_output_voltage_target = 12'h050;
        4'h2: strap_output_voltage_target = 12'h064;
        4'h3: strap_output_voltage_target = 12'h078;
        4'h4: strap_output_voltage_target = 12'h096;
        4'h5: strap_output_voltage_target = 12'h0B4;
        4'h6: strap_output_voltage_target = 12'h0FA;
        4'h7: strap_output_voltage_target = 12'h14A;
        default: strap_output_voltage_target = 12'h1F4;
      endcase
    end
  endfunction

  // Single-resistor table, 31 entries in 10 mV units.
  function [11:0] single_output_voltage_target;
    input [4:0] i;
    begin
      case (i)
        5'h00: single_output_voltage_target = 12'h03C;
        5'h01: single_output_voltage_target = 12'h041;
        5'h02: single_output_voltage_target = 12'h046;
        5'h03: single_output_voltage_target = 12'h04B;
        5'h04: single_output_voltage_target = 12'h050;
        5'h05: single_output_voltage_target = 12'h055;
        5'h06: single_output_voltage_target = 12'h05A;
        5'h07: single_output_voltage_target = 12'h05F;
        5'h08: single_output_voltage_target = 12'h064;
        5'h09: single_output_voltage_target = 12'h069;
        5'h0A: single_output_voltage_target = 12'h06E;
        5'h0B: single_output_voltage_target = 12'h073;
        5'h0C: single_output_voltage_target = 12'h078;
        5'h0D: single_output_voltage_target = 12'h07D;
        5'h0E: single_output_voltage_target = 12'h082;
        5'h0F: single_output_voltage_target = 12'h08C;
        5'h10: single_output_voltage_target = 12'h096;
        5'h11: single_output_voltage_target = 12'h0A0;
        5'h12: single_output_voltage_target = 12'h0AA;
        5'h13: single_output_voltage_target = 12'h0B4;
        5'h14: single_output_voltage_target = 12'h0BE;
        5'h15: single_output_voltage_target = 12'h0C8;
        5'h16: single_output_voltage_target = 12'h0D2;
        5'h17: single_output_voltage_target = 12'h0DC;
        5'h18: single_output_voltage_target = 12'h0E6;
        5'h19: single_output_voltage_target = 12'h0FA;
        5'h1A: single_output_voltage_target = 12'h12C;
        5'h1B: single_output_voltage_target = 12'h14A;
        5'h1C: single_output_voltage_target = 12'h190;
        5'h1D: single_output_voltage_target = 12'h1F4;
        default: single_output_voltage_target = 12'h226;
      endcase
    end
  endfunction

  // Clamp a ladder index to the 25-entry ladder.
  function [4:0] ladder;
    input [4:0] i;
    begin
      ladder = (i > `MAX_LADDER_INDEX) ? `MAX_LADDER_INDEX : i;
    end
  endfunction

  // Mode-dependent minimum turn-on delay in ms.
  function [7:0] min_delay;
    input [2:0] m;
    begin
      // Sharing together with autocomp or low power needs the longest wait.
      if (m[`MODE_SHARE_BIT] && (m[`MODE_AUTOCOMP_BIT] || m[`MODE_LOWPWR_BIT]))
        min_delay = `MIN_DLY_15_MS;
      else if (m[`MODE_LOWPWR_BIT])
        min_delay = `MIN_DLY_10_MS;
      else
        min_delay = `MIN_DLY_5_MS;
    end
  endfunction

  // ==========================================================================
  // Registers.
  reg [4:0] state_q;
  reg [23:0] cnt_q;
  reg [15:0] ms_cnt_q;
  reg [7:0] delay_ms_q;
  reg [2:0] mode_q;
  reg [7:0] target_ms_q;
  // Decoded values that the sequencer picks from.
  wire [11:0] two_res_output_voltage_target;
  wire [7:0] eff_delay;
  wire busy;

  // The ladder sum is the two-resistor target; index 0 means 0 mV offset.
  assign two_res_output_voltage_target = {7'h00, ladder(fine_res_index)} +
                        (`COARSE_MULT * {7'h00, ladder(coarse_res_index)});
  // Configured delays below the minimum are raised to it.
  assign eff_delay = (delay_ms_q < min_delay(mode_q)) ? min_delay(mode_q) : delay_ms_q;
  assign busy = (state_q == S_NVM) || (state_q == S_PINS);

  // ==========================================================================
  // Sequencer. Bus writes and enable are dropped while busy, so a host
  // cannot corrupt values that the loader is about to overwrite.
  always @(posedge clock)
  begin
    if (rst)
    begin
      // Defaults hold until the loader has run its course.
      state_q <= S_NVM;
      cnt_q <= 24'h000000;
      ms_cnt_q <= 16'h0000;
      delay_ms_q <= `DELAY_DEFAULT_MS;
      mode_q <= 3'h0;
      target_ms_q <= 8'h00;
      ready <= 1'b0;
      ramp_start <= 1'b0;
      ramp_time_ms <= `RAMP_DEFAULT_MS;
      output_voltage_target <= `OUTPUT_VOLTAGE_TARGET_DEFAULT_10MV;
    end
    else if (clk_en)
    begin
      ramp_start <= 1'b0;
      case (state_q)
        S_NVM:
        begin
          // Count out the memory check; enable and bus traffic have no effect here.
          ready <= 1'b0;
          if (cnt_q >= NVM_CYC - 24'h000001)
          begin
            cnt_q <= 24'h000000;
            state_q <= S_PINS;
            if (nvm_valid)
            begin
              output_voltage_target <= nvm_output_voltage_target;
              delay_ms_q <= nvm_delay_ms;
              ramp_time_ms <= nvm_ramp_ms;
              mode_q <= nvm_mode;
            end
          end
          else
            cnt_q <= cnt_q + 24'h000001;
        end
        S_PINS:
        begin
          // Pins are only looked at here, reached from reset or restore.
          if (cnt_q == `PIN_SAMPLE_CYCLES - 24'h000001)
          begin
            cnt_q <= 24'h000000;
            state_q <= S_READY;
            ready <= 1'b1;
            if (!nvm_valid)
            begin
              // Single-resistor mode needs the fine pin low; a resistor on either pin means the pair.
              if (fine_select_pin == `STRAP_LOW && coarse_select_pin == `STRAP_RES)
                output_voltage_target <= single_output_voltage_target(coarse_res_index);
              else if (fine_select_pin == `STRAP_RES || coarse_select_pin == `STRAP_RES)
                output_voltage_target <= two_res_output_voltage_target;
              else
                output_voltage_target <= strap_output_voltage_target(coarse_select_pin, fine_select_pin);
              // Strap classes give fixed delay and ramp pairs; a resistor gives its decoded pair.
              case (ss_pin)
                `STRAP_LOW:
                begin
                  delay_ms_q <= 8'h05;
                  ramp_time_ms <= 8'h02;
                end
                `STRAP_OPEN:
                begin
                  delay_ms_q <= 8'h05;
                  ramp_time_ms <= 8'h05;
                end
                `STRAP_HIGH:
                begin
                  delay_ms_q <= 8'h0A;
                  ramp_time_ms <= 8'h0A;
                end
                default:
                begin
                  delay_ms_q <= ss_delay_ms;
                  ramp_time_ms <= ss_ramp_ms;
                end
              endcase
            end
          end
          else
            cnt_q <= cnt_q + 24'h000001;
        end
        S_READY:
        begin
          // Enable is a level, so one held high since reset starts here.
          if (enable_in)
          begin
            state_q <= S_DELAY;
            target_ms_q <= eff_delay;
            ms_cnt_q <= 16'h0000;
            cnt_q <= 24'h000000;
          end
        end
        S_DELAY:
        begin
          // Dropping enable aborts the delay; the next enable starts the count afresh.
          if (!enable_in)
            state_q <= S_READY;
          else if (cnt_q[7:0] >= target_ms_q)
          begin
            state_q <= S_RAMP;
            ramp_start <= 1'b1;
          end
          // One step of cnt_q is one millisecond of the pre-ramp delay.
          else if (ms_cnt_q == MS_CYC - 16'h0001)
          begin
            ms_cnt_q <= 16'h0000;
            cnt_q <= cnt_q + 24'h000001;
          end
          else
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
        S_RAMP:
        begin
          // The ramp is shaped elsewhere; this state only waits for enable to drop.
          if (!enable_in)
            state_q <= S_READY;
        end
        // An illegal state code restarts the load rather than hanging.
        default:
          state_q <= S_NVM;
      endcase

      // Register writes, honoured only when not loading.
      if (wr && !busy)
      begin
        case (addr)
          `ADDR_CMD:
          begin
            // Restore repeats the whole load, starting again from the memory check.
            if (wdata[`CMD_RESTORE_BIT])
            begin
              state_q <= S_NVM;
              cnt_q <= 24'h000000;
              ready <= 1'b0;
            end
          end
          `ADDR_OUTPUT_VOLTAGE_TARGET:
          begin
            // An out-of-range target is dropped whole and the old target stays.
            if (wdata[11:0] >= `OUTPUT_VOLTAGE_TARGET_MIN_10MV && wdata[11:0] <= `OUTPUT_VOLTAGE_TARGET_MAX_10MV)
              output_voltage_target <= wdata[11:0];
          end
          `ADDR_DELAY:
            delay_ms_q <= wdata[7:0];
          `ADDR_RAMP:
            ramp_time_ms <= wdata[7:0];
          `ADDR_MODE:
            mode_q <= wdata[2:0];
          default:
          begin
            // Status and unmapped offsets take no writes.
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Read port; reads while loading return zero because traffic is ignored.
  always @(posedge clock)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (clk_en)
    begin
      if (rd && !busy)
      begin
        case (addr)
          `ADDR_OUTPUT_VOLTAGE_TARGET: rdata <= {4'h0, output_voltage_target};
          `ADDR_DELAY: rdata <= {8'h00, delay_ms_q};
          `ADDR_RAMP: rdata <= {8'h00, ramp_time_ms};
          `ADDR_MODE: rdata <= {13'h0000, mode_q};
          // Status packs the one-hot state above the effective delay.
          `ADDR_STATUS: rdata <= {3'h0, state_q, eff_delay};
          default: rdata <= 16'h0000;
        endcase
      end
      else
        rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: startup_consts.vh
// Constants for the start-up configuration sequencer.
// Operation
// - Two-resistor target in 10 mV units equals fine index plus 25 times coarse index.
// - Each select resistor decodes to ladder index 0 (10k) through 24 (100k).
// - Fine pin low with coarse resistor selects one of 31 fixed voltages 0.60-5.50 V.
// - Bus-written target accepted between 0.6 V and 5.0 V.
// - After reset spend the memory-check time, loading stored user values if present.
// - After memory check, if no stored values were loaded, sample every multi-mode pin and load its configuration.
// - Enable and bus traffic are ignored during memory check and pin sampling.
// - Ready only after loading; then bus commands and enable are honoured.
// - A restore command repeats the memory check as at power-up.
// - A configured delay below the mode minimum is replaced by the minimum.
// - A configured delay above the minimum is waited in full.
// - When the delay expires, start the ramp with the configured ramp time.
// - Enable held from power-up still waits for the loading period.
// - Minimum delay is 5, 10 or 15 ms by sharing, autocomp and low-power mode.
// - The delay starts timing when enable is asserted and ends on expiry.
// - Pins are sampled only at power-up or restore, never otherwise.
`ifndef STARTUP_CONSTS_VH
`define STARTUP_CONSTS_VH
`define CLK_HZ 10000000
`define MS_PER_S 1000
`define NVM_CHECK_MS 8
`define PIN_SAMPLE_CYCLES 24'h000004
`define MIN_DLY_5_MS 8'h05
`define MIN_DLY_10_MS 8'h0A
`define MIN_DLY_15_MS 8'h0F
`define COARSE_MULT 12'h019
`define MAX_LADDER_INDEX 5'h18
`define OUTPUT_VOLTAGE_TARGET_MIN_10MV 12'h03C
`define OUTPUT_VOLTAGE_TARGET_MAX_10MV 12'h1F4
`define OUTPUT_VOLTAGE_TARGET_DEFAULT_10MV 12'h064
`define DELAY_DEFAULT_MS 8'h05
`define RAMP_DEFAULT_MS 8'h05
`define STRAP_LOW 3'h0
`define STRAP_OPEN 3'h1
`define STRAP_HIGH 3'h2
`define STRAP_RES 3'h3
`define ADDR_OUTPUT_VOLTAGE_TARGET 4'h0
`define ADDR_DELAY 4'h1
`define ADDR_RAMP 4'h2
`define ADDR_MODE 4'h3
`define ADDR_CMD 4'h4
`define ADDR_STATUS 4'h5
`define MODE_SHARE_BIT 0
`define MODE_AUTOCOMP_BIT 1
`define MODE_LOWPWR_BIT 2
`define CMD_RESTORE_BIT 0
`endif

// file: startup_properties.sv
// Assertion checker for the start-up configuration sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "startup_consts.vh"
module seq_checker #(
  parameter NVM_CHECK_CYCLES = 20,
  parameter CYCLES_PER_MS = 4
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Bus and enable inputs.
  input wire logic enable_in,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  // Watched outputs.
  input wire logic [15:0] rdata,
  input wire logic ready,
  input wire logic ramp_start,
  input wire logic [11:0] output_voltage_target
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !clk_en);
  logic [19:0] busy_q;
  logic [19:0] en_q;
  // Counters of loading cycles and of enabled-while-ready cycles; they saturate rather than wrap,
  // and hold while the clock enable freezes the design.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      busy_q <= 20'h00000;
      en_q <= 20'h00000;
    end
    else if (clk_en)
    begin
      busy_q <= ready ? 20'h00000 : busy_q + {19'h00000, ~&busy_q};
      en_q <= (!ready || !enable_in) ? 20'h00000 : en_q + {19'h00000, ~&en_q};
    end
  end
  sequence s_restore_req;
    ready && wr && addr == `ADDR_CMD && wdata[`CMD_RESTORE_BIT];
  endsequence
  sequence s_reloading;
    !ready [*2];
  endsequence
  property p_restore;
    s_restore_req |=> s_reloading;
  endproperty
  property p_load;
    $rose(ready) |-> busy_q >= NVM_CHECK_CYCLES;
  endproperty
  property p_ramp_ready;
    ramp_start |-> ready;
  endproperty
  property p_min_delay;
    ramp_start |-> en_q >= 5 * CYCLES_PER_MS;
  endproperty
  property p_ramp_pulse;
    ramp_start |=> !ramp_start;
  endproperty
  property p_busy_read;
    rd && !ready |=> rdata == 16'h0000;
  endproperty
  property p_hold_target;
    ready && !wr |=> $stable(output_voltage_target);
  endproperty
  property p_output_voltage_target_range;
    ready && wr && addr == `ADDR_OUTPUT_VOLTAGE_TARGET && (wdata[11:0] > `OUTPUT_VOLTAGE_TARGET_MAX_10MV || wdata[11:0] < `OUTPUT_VOLTAGE_TARGET_MIN_10MV)
      |=> $stable(output_voltage_target);
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore did not restart loading");
  a_load: assert property (p_load)
    else $error("ready came before the memory check ended");
  a_ramp_ready: assert property (p_ramp_ready)
    else $error("ramp started while not ready");
  a_min_delay: assert property (p_min_delay)
    else $error("ramp came before the minimum delay");
  a_ramp_pulse: assert property (p_ramp_pulse)
    else $error("ramp start longer than one cycle");
  a_busy_read: assert property (p_busy_read)
    else $error("bus answered while loading");
  a_hold_target: assert property (p_hold_target)
    else $error("target changed without a write");
  a_output_voltage_target_range: assert property (p_output_voltage_target_range)
    else $error("out of range target accepted");
endmodule
bind startup_config_sequencer seq_checker #(.NVM_CHECK_CYCLES(NVM_CHECK_CYCLES), .CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
  .clock(clock), .rst(rst), .clk_en(clk_en), .enable_in(enable_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata),
  .ready(ready), .ramp_start(ramp_start), .output_voltage_target(output_voltage_target));
`default_nettype wire

// file: strap_board.sv
// Board strap model: a resistor pair set for a wanted target, or one resistor at index SINGLE_INDEX.
`timescale 1ns/1ps
`default_nettype none
module strap_board #(
  parameter SINGLE_INDEX = 21
)
(
  // Wanted target in 10 mV steps, and choice of single resistor.
  input wire logic [11:0] target_10mv,
  input wire logic single_mode,
  // Strap class and ladder index of each select pin.
  output logic [2:0] fine_select_pin,
  output logic [4:0] fine_res_index,
  output logic [2:0] coarse_select_pin,
  output logic [4:0] coarse_res_index
);
  // Coarse is 4*V rounded down and fine is the rest; single mode ties the fine pin low.
  always_comb
  begin
    coarse_select_pin = 3'h3;
    coarse_res_index = single_mode ? 5'(SINGLE_INDEX) : 5'(target_10mv / 12'h019);
    fine_select_pin = single_mode ? 3'h0 : 3'h3;
    fine_res_index = single_mode ? 5'h1F : 5'(target_10mv - 12'h019 * coarse_res_index);
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the start-up configuration sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "startup_consts.vh"
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic single = 1'b0;
  logic nvm_valid = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [11:0] tgt = 12'h085;
  logic [7:0] ss_dly = 8'h02;
  logic [7:0] ss_ramp = 8'h07;
  logic clk_en = 1'b1;
  logic [2:0] ss_pin = 3'h3;
  logic [2:0] nvm_mode = 3'h0;
  logic [2:0] modes [6] = '{3'h0, 3'h4, 3'h6, 3'h5, 3'h1, 3'h3};
  logic [7:0] dlys [6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h14};
  logic [7:0] effs [6] = '{8'h05, 8'h0A, 8'h0A, 8'h0F, 8'h05, 8'h14};
  wire [2:0] fsel;
  wire [2:0] csel;
  wire [4:0] fidx;
  wire [4:0] cidx;
  wire [15:0] rdata;
  wire ready;
  wire ramp_start;
  wire [7:0] rtime;
  wire [11:0] vtgt;
  int err_count = 0;
  int total_checks = 0;
  strap_board board (.target_10mv(tgt), .single_mode(single), .fine_select_pin(fsel), .fine_res_index(fidx),
    .coarse_select_pin(csel), .coarse_res_index(cidx));
  // Short counts keep the run brief; expectations below use 20 and 4.
  startup_config_sequencer #(.NVM_CHECK_CYCLES(20), .CYCLES_PER_MS(4)) DUT (.clock(clock), .rst(rst),
    .clk_en(clk_en), .nvm_valid(nvm_valid), .nvm_output_voltage_target(12'h0FA), .nvm_delay_ms(8'h0C), .nvm_ramp_ms(8'h09),
    .nvm_mode(nvm_mode), .fine_select_pin(fsel), .fine_res_index(fidx), .coarse_select_pin(csel),
    .coarse_res_index(cidx), .ss_pin(ss_pin), .ss_delay_ms(ss_dly), .ss_ramp_ms(ss_ramp), .enable_in(en),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ready(ready), .ramp_start(ramp_start),
    .ramp_time_ms(rtime), .output_voltage_target(vtgt));
  // Clock at 100 ns period, running from time zero so it is steady long before reset is released.
  initial
  begin
    forever #50 clock = ~clock;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
  begin
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // Each access ends with an idle edge so no strobe is set twice in one step.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m, input string what);
    logic [15:0] v;
  begin
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    v = rdata & m;
    check(what, exp, v);
  end
  endtask
  task automatic wait_ready;
  begin
    for (int n = 0; n < 200 && ready !== 1'b1; n++)
      @(posedge clock);
    check("ready", 16'h0001, {15'h0000, ready});
  end
  endtask
  // Cycles from enable to ramp must lie between ms*4 and a few cycles past ms*5.
  task automatic ramp(input int ms);
    int n;
  begin
    n = 0;
    en <= 1'b1;
    while (ramp_start !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    check("ramp delay", 16'h0001, {15'h0000, n >= ms * 4 && n <= ms * 5 + 4});
    en <= 1'b0;
    @(posedge clock);
  end
  endtask
  task automatic conclude;
  begin
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // Enable is held from power-up, so the first ramp may only follow loading.
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd_chk(`ADDR_OUTPUT_VOLTAGE_TARGET, 16'h0000, 16'hFFFF, "early read");
    wait_ready;
    ramp(5);
    check("ramp time", 16'h0007, {8'h00, rtime});
    check("pair target", 16'h0085, {4'h0, vtgt});
    $display("test power-up done");
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(`ADDR_MODE, {13'h0000, modes[i]});
      wr_reg(`ADDR_DELAY, {8'h00, dlys[i]});
      rd_chk(`ADDR_STATUS, {8'h00, effs[i]}, 16'h00FF, "eff delay");
    end
    ramp(20);
    $display("test delay modes done");
    wr_reg(`ADDR_OUTPUT_VOLTAGE_TARGET, 16'h01F5);
    rd_chk(`ADDR_OUTPUT_VOLTAGE_TARGET, 16'h0085, 16'hFFFF, "output_voltage_target high");
    wr_reg(`ADDR_OUTPUT_VOLTAGE_TARGET, 16'h003C);
    rd_chk(`ADDR_OUTPUT_VOLTAGE_TARGET, 16'h003C, 16'hFFFF, "output_voltage_target low edge");
    wr_reg(`ADDR_OUTPUT_VOLTAGE_TARGET, 16'h003B);
    rd_chk(`ADDR_OUTPUT_VOLTAGE_TARGET, 16'h003C, 16'hFFFF, "output_voltage_target below range");
    clk_en <= 1'b0;
    wr_reg(`ADDR_OUTPUT_VOLTAGE_TARGET, 16'h0064);
    clk_en <= 1'b1;
    check("frozen target", 16'h003C, {4'h0, vtgt});
    tgt <= 12'h12C;
    rd_chk(4'hF, 16'h0000, 16'hFFFF, "unmapped");
    check("kept target", 16'h003C, {4'h0, vtgt});
    $display("test bus done");
    single <= 1'b1;
    ss_pin <= `STRAP_HIGH;
    wr_reg(`ADDR_CMD, 16'h0001);
    check("ready in restore", 16'h0000, {15'h0000, ready});
    wr_reg(`ADDR_MODE, 16'h0000);
    wait_ready;
    check("single target", 16'h00C8, {4'h0, vtgt});
    check("strap ramp", 16'h000A, {8'h00, rtime});
    rd_chk(`ADDR_DELAY, 16'h000A, 16'hFFFF, "strap delay");
    rd_chk(`ADDR_MODE, 16'h0003, 16'hFFFF, "mode kept");
    nvm_valid <= 1'b1;
    nvm_mode <= 3'h4;
    wr_reg(`ADDR_CMD, 16'h0001);
    wait_ready;
    check("stored target", 16'h00FA, {4'h0, vtgt});
    check("stored ramp", 16'h0009, {8'h00, rtime});
    rd_chk(`ADDR_STATUS, 16'h000C, 16'h00FF, "stored delay");
    rd_chk(`ADDR_MODE, 16'h0004, 16'hFFFF, "stored mode");
    $display("test restore done");
    conclude;
  end
  // Cuts a hang short; the tests need under a thousand cycles.
  initial
  begin
    #400000;
    err_count++;
    conclude;
  end
endmodule
`default_nettype wire
